// ==== src/link_diag_regs.v ====
// Purpose: Diagnostic, physical-layer access and interface state registers
// Assumes: Host bus on core clock; RAM returns read data one cycle after its read strobe
// Notes:   Physical-layer pins pass two flip-flops before any logic looks at them
`timescale 1ns/1ps
`include "link_diag_defs.vh"
module link_diag_regs (
   input  wire                   core_clk_i,
   input  wire                   rst_i,
   input  wire [7:0]             host_addr_i,
   input  wire [31:0]            host_wdata_i,
   input  wire                   host_wr_i,
   input  wire                   host_rd_i,
   output reg  [31:0]            host_rdata_o,
   output reg                    host_ack_o,
   input  wire [1:0]             phy_ctl_i,
   input  wire [1:0]             phy_data_i,
   output reg                    phy_lreq_o,
   output reg                    phy_info_received_irq_o,
   output reg                    snoop_all_enable_o,
   output reg                    busy_ack_select_o,
   output reg                    memory_selftest_mode_o,
   output reg  [`RAM_ADDR_W-1:0] ram_addr_o,
   output reg  [31:0]            ram_wdata_o,
   output reg                    ram_tag_o,
   output reg                    ram_we_o,
   output reg                    ram_re_o,
   input  wire [31:0]            ram_rdata_i,
   input  wire                   ram_tag_i,
   input  wire [3:0]             tx_iface_fsm_state_i,
   input  wire [2:0]             rx_data_iface_fsm_state_i,
   input  wire [2:0]             rx_ack_fsm_state_i
);
   // Diagnostic fields
   reg                    snoop_all_enable;
   reg                    busy_ack_select;
   reg                    arb_reset_gap_seen;
   reg                    fair_gap_seen;
   reg                    register_write_unlock;
   reg                    test_tag_bit_value;
   reg                    tag_mismatch;
   reg                    memory_selftest_bit;
   // Access register fields
   reg                    phy_read_request;
   reg                    phy_write_request;
   reg [3:0]              phy_target_addr;
   reg [7:0]              phy_write_byte;
   reg [3:0]              phy_returned_addr;
   reg [7:0]              phy_returned_byte;
   // Self-test path
   reg [`RAM_ADDR_W-1:0]  ram_ptr;
   reg [1:0]              rd_pipe;
   // Pin synchronisers and gap counter
   reg [1:0]              ctl_meta;
   reg [1:0]              ctl_sync;
   reg [1:0]              data_meta;
   reg [1:0]              data_sync;
   reg [`GAP_CNT_W-1:0]   idle_cnt;

   wire                   selftest_active;
   wire                   wr_diag;
   wire                   wr_access;
   wire                   test_access;
   wire                   req_accepted;
   wire                   lreq_bit;
   wire [3:0]             req_state;
   wire                   stat_valid;
   wire [3:0]             stat_addr;
   wire [7:0]             stat_byte;
   wire [1:0]             rx_status_state;
   wire [31:0]            diag_word;
   wire [31:0]            access_word;
   wire [31:0]            state_word;
   wire [31:0]            diag_next;

   // Lockable diagnostic bits only take host writes while unlocked
   function [31:0] masked_write;
      input [31:0] old_val;
      input [31:0] new_val;
      input [31:0] mask;
      begin
         masked_write = (old_val & ~mask) | (new_val & mask);
      end
   endfunction

   function addr_hit;
      input [7:0] addr;
      input [7:0] target;
      begin
         addr_hit = (addr == target);
      end
   endfunction

   assign selftest_active = memory_selftest_bit & register_write_unlock;
   assign wr_diag         = host_wr_i & addr_hit(host_addr_i, `ADDR_DIAG);
   assign wr_access       = host_wr_i & addr_hit(host_addr_i, `ADDR_ACCESS);
   assign test_access     = selftest_active & addr_hit(host_addr_i, `ADDR_MEMORY_SELFTEST_MODE);

   // Bit 0 as printed is hardware bit 31; address clear always reads zero
   assign diag_word = {snoop_all_enable, busy_ack_select, arb_reset_gap_seen,
                       fair_gap_seen, register_write_unlock, 1'b0, test_tag_bit_value,
                       tag_mismatch, memory_selftest_bit, 23'h000000};

   assign access_word = {phy_read_request, phy_write_request, 2'h0, phy_target_addr,
                         phy_write_byte, 4'h0, phy_returned_addr,
                         phy_returned_byte};

   assign state_word = {16'h0000, req_state, tx_iface_fsm_state_i,
                        rx_data_iface_fsm_state_i, rx_status_state,
                        rx_ack_fsm_state_i};

   assign diag_next = masked_write(diag_word, host_wdata_i,
                                   register_write_unlock ? `D_LOCKED_MASK_V
                                                         : `D_LOCKED_MASK);

   phy_request_tx u_req_tx (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .start_rd_i (phy_read_request),
      .start_wr_i (phy_write_request),
      .addr_i     (phy_target_addr),
      .byte_i     (phy_write_byte),
      .accepted_o (req_accepted),
      .lreq_o     (lreq_bit),
      .state_o    (req_state)
   );

   phy_status_rx u_stat_rx (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .ctl_i      (ctl_sync),
      .data_i     (data_sync),
      .valid_o    (stat_valid),
      .addr_o     (stat_addr),
      .byte_o     (stat_byte),
      .state_o    (rx_status_state)
   );

   always @(posedge core_clk_i) begin
      if (rst_i) begin
         ctl_meta  <= 2'h0;
         ctl_sync  <= 2'h0;
         data_meta <= 2'h0;
         data_sync <= 2'h0;
      end else begin
         ctl_meta  <= phy_ctl_i;
         ctl_sync  <= ctl_meta;
         data_meta <= phy_data_i;
         data_sync <= data_meta;
      end
   end

   // Idle gap counter saturates so each gap flags once
   always @(posedge core_clk_i) begin
      if (rst_i) begin
         idle_cnt <= {`GAP_CNT_W{1'b0}};
      end else if (ctl_sync != `PHY_CTL_IDLE) begin
         idle_cnt <= {`GAP_CNT_W{1'b0}};
      end else if (idle_cnt != `ARB_GAP_CYC) begin
         idle_cnt <= idle_cnt + {{(`GAP_CNT_W-1){1'b0}}, 1'b1};
      end
   end

   // Diagnostic register; hardware sets win over host writes
   always @(posedge core_clk_i) begin
      if (rst_i) begin
         snoop_all_enable      <= 1'b0;
         busy_ack_select       <= 1'b0;
         arb_reset_gap_seen    <= 1'b0;
         fair_gap_seen         <= 1'b0;
         register_write_unlock <= 1'b0;
         test_tag_bit_value    <= 1'b0;
         tag_mismatch          <= 1'b0;
         memory_selftest_bit   <= 1'b0;
      end else begin
         if (wr_diag) begin
            snoop_all_enable      <= diag_next[`D_SNOOP];
            busy_ack_select       <= diag_next[`D_BUSY];
            arb_reset_gap_seen    <= diag_next[`D_ARB];
            fair_gap_seen         <= diag_next[`D_FAIR];
            register_write_unlock <= diag_next[`D_UNLOCK];
            test_tag_bit_value    <= diag_next[`D_TAGVAL];
            tag_mismatch          <= diag_next[`D_TAGERR];
            memory_selftest_bit   <= diag_next[`D_SELFTEST];
            if (diag_next[`D_ADRCLR]) begin
               tag_mismatch <= 1'b0;
            end
         end
         if (ctl_sync == `PHY_CTL_IDLE && idle_cnt == `ARB_GAP_CYC - 1) begin
            arb_reset_gap_seen <= 1'b1;
         end
         if (ctl_sync == `PHY_CTL_IDLE && idle_cnt == `FAIR_GAP_CYC - 1) begin
            fair_gap_seen <= 1'b1;
         end
         if (rd_pipe[1] && ram_tag_i != test_tag_bit_value) begin
            tag_mismatch <= 1'b1;
         end
      end
   end

   // Self-test RAM path
   always @(posedge core_clk_i) begin
      if (rst_i) begin
         ram_ptr     <= {`RAM_ADDR_W{1'b0}};
         ram_addr_o  <= {`RAM_ADDR_W{1'b0}};
         ram_wdata_o <= 32'h00000000;
         ram_tag_o   <= 1'b0;
         ram_we_o    <= 1'b0;
         ram_re_o    <= 1'b0;
         rd_pipe     <= 2'h0;
      end else begin
         ram_we_o <= 1'b0;
         ram_re_o <= 1'b0;
         rd_pipe  <= {rd_pipe[0], 1'b0};
         if (test_access && (host_wr_i || host_rd_i)) begin
            ram_addr_o <= ram_ptr;
            ram_ptr    <= ram_ptr + {{(`RAM_ADDR_W-1){1'b0}}, 1'b1};
            if (host_wr_i) begin
               ram_we_o    <= 1'b1;
               ram_wdata_o <= host_wdata_i;
               ram_tag_o   <= test_tag_bit_value;
            end else begin
               ram_re_o   <= 1'b1;
               rd_pipe[0] <= 1'b1;
            end
         end else if (wr_diag && diag_next[`D_ADRCLR]) begin
            ram_ptr <= {`RAM_ADDR_W{1'b0}};
         end
      end
   end

   // Access register; request bits clear once the serialiser takes them
   always @(posedge core_clk_i) begin
      if (rst_i) begin
         phy_read_request  <= 1'b0;
         phy_write_request <= 1'b0;
         phy_target_addr   <= 4'h0;
         phy_write_byte    <= 8'h00;
         phy_returned_addr <= 4'h0;
         phy_returned_byte <= 8'h00;
      end else begin
         if (req_accepted) begin
            if (phy_read_request) begin
               phy_read_request <= 1'b0;
            end else begin
               phy_write_request <= 1'b0;
            end
         end
         if (wr_access) begin
            if (host_wdata_i[`A_RD]) begin
               phy_read_request <= 1'b1;
            end
            if (host_wdata_i[`A_WR]) begin
               phy_write_request <= 1'b1;
            end
            phy_target_addr <= host_wdata_i[`A_TADDR_HI:`A_TADDR_LO];
            phy_write_byte  <= host_wdata_i[`A_WBYTE_HI:`A_WBYTE_LO];
         end
         if (stat_valid) begin
            phy_returned_addr <= stat_addr;
            phy_returned_byte <= stat_byte;
         end
      end
   end

   // Host read data and acknowledge; unmapped reads return zero
   always @(posedge core_clk_i) begin
      if (rst_i) begin
         host_rdata_o <= `REG_RESET;
         host_ack_o   <= 1'b0;
      end else begin
         host_ack_o <= 1'b0;
         if (rd_pipe[1]) begin
            host_rdata_o <= ram_rdata_i;
            host_ack_o   <= 1'b1;
         end else if (host_wr_i) begin
            host_ack_o <= 1'b1;
         end else if (host_rd_i && !test_access) begin
            host_ack_o <= 1'b1;
            if (addr_hit(host_addr_i, `ADDR_DIAG)) begin
               host_rdata_o <= diag_word;
            end else if (addr_hit(host_addr_i, `ADDR_ACCESS)) begin
               host_rdata_o <= access_word;
            end else if (addr_hit(host_addr_i, `ADDR_STATE)) begin
               host_rdata_o <= state_word;
            end else begin
               host_rdata_o <= `REG_RESET;
            end
         end
      end
   end

   // Mode and event outputs from flip-flops
   always @(posedge core_clk_i) begin
      if (rst_i) begin
         snoop_all_enable_o      <= 1'b0;
         busy_ack_select_o       <= 1'b0;
         memory_selftest_mode_o  <= 1'b0;
         phy_info_received_irq_o <= 1'b0;
         phy_lreq_o              <= 1'b0;
      end else begin
         snoop_all_enable_o      <= snoop_all_enable;
         busy_ack_select_o       <= busy_ack_select;
         memory_selftest_mode_o  <= selftest_active;
         phy_info_received_irq_o <= stat_valid;
         phy_lreq_o              <= lreq_bit;
      end
   end
endmodule

// ==== src/link_diag_defs.vh ====
// Purpose: Constants for the link diagnostic and physical-layer access registers
// Assumes: 50 MHz core clock; documented bit 0 is the most significant hardware bit
// Notes:   Hardware bit index = 31 - documented bit index
//
// Behaviour
// - Unlock and snoop bits always writable; other diagnostic bits writable only when unlocked.
// - Each host test access advances the internal RAM address counter by one.
// - Snoop enable makes the receiver accept every packet in snoop layout.
// - Busy select chooses ack_busyB when set, ack_busyA when clear, for next refusal.
// - Arbitration reset gap flag sets when bus idles for an arbitration reset gap.
// - Fair gap flag sets when bus idles for a subaction gap.
// - Address clear resets RAM address counter and clears control-bit mismatch flag.
// - Each test write stores the test control-bit value into RAM bit 33.
// - In test mode a RAM control bit unequal to test value sets mismatch flag.
// - Test mode active only with test bit and unlock both set; bits 9-31 reserved.
// - Access register upper half carries requests, lower half holds physical-layer replies.
// - Read request bit sends register read, then clears once the serialiser accepts it.
// - Write request bit sends register write with address and byte, then self-clears.
// - Target address in bits 4-7, write byte in bits 8-15, bits 2-3 reserved.
// - Returned address goes to bits 20-23, returned byte to bits 24-31.
// - New physical-layer register information updates fields and raises the info interrupt.
// - Bit 0 is most significant; request half bits 0-15, response half 16-31.
// - Debug register shows request state bits 16-19, transmit state bits 20-23.
// - Debug register shows receive data 24-26, status 27-28, acknowledge 29-31.
`ifndef LINK_DIAG_DEFS_VH
`define LINK_DIAG_DEFS_VH

`define CLK_PERIOD_NS   20
`define FAIR_GAP_NS     1000
`define ARB_GAP_NS      2000
`define FAIR_GAP_CYC    ((`FAIR_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ARB_GAP_CYC     ((`ARB_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GAP_CNT_W       8

`define ADDR_DIAG       8'h20
`define ADDR_ACCESS     8'h24
`define ADDR_STATE      8'h28
`define ADDR_MEMORY_SELFTEST_MODE    8'h80
`define REG_RESET       32'h00000000
`define RAM_ADDR_W      8

`define D_SNOOP         31
`define D_BUSY          30
`define D_ARB           29
`define D_FAIR          28
`define D_UNLOCK        27
`define D_ADRCLR        26
`define D_TAGVAL        25
`define D_TAGERR        24
`define D_SELFTEST      23
`define D_LOCKED_MASK   32'h88000000
`define D_LOCKED_MASK_V 32'hFF800000

`define A_RD            31
`define A_WR            30
`define A_TADDR_HI      27
`define A_TADDR_LO      24
`define A_WBYTE_HI      23
`define A_WBYTE_LO      16
`define A_RADDR_HI      11
`define A_RADDR_LO      8
`define A_RBYTE_HI      7
`define A_RBYTE_LO      0

`define S_REQ_HI        15
`define S_REQ_LO        12
`define S_TX_HI         11
`define S_TX_LO         8
`define S_RXD_HI        7
`define S_RXD_LO        5
`define S_RXS_HI        4
`define S_RXS_LO        3
`define S_RXA_HI        2
`define S_RXA_LO        0

`define LREQ_TYPE_RD    3'h1
`define LREQ_TYPE_WR    3'h5
`define LREQ_LEN_RD     5'h09
`define LREQ_LEN_WR     5'h11
`define LREQ_W          17

`define PHY_CTL_IDLE    2'h0
`define PHY_CTL_STATUS  2'h1
`define STAT_PAIRS      3'h7

`endif

// ==== src/phy_request_tx.v ====
// Purpose: Serialises register read and write requests onto the request line
// Assumes: One bit per core clock, start bit first, stop bit last
// Notes:   Read requests carry no data byte and are shorter
`timescale 1ns/1ps
`include "link_diag_defs.vh"
module phy_request_tx (
   input  wire       core_clk_i,
   input  wire       rst_i,
   input  wire       start_rd_i,
   input  wire       start_wr_i,
   input  wire [3:0] addr_i,
   input  wire [7:0] byte_i,
   output reg        accepted_o,
   output reg        lreq_o,
   output wire [3:0] state_o
);
   localparam ST_IDLE  = 1'b0;
   localparam ST_SHIFT = 1'b1;

   reg                  state;
   reg [`LREQ_W-1:0]    shreg;
   reg [4:0]            remain;

   assign state_o = {3'h0, state};

   always @(posedge core_clk_i) begin
      if (rst_i) begin
         state      <= ST_IDLE;
         shreg      <= {`LREQ_W{1'b0}};
         remain     <= 5'h00;
         accepted_o <= 1'b0;
         lreq_o     <= 1'b0;
      end else begin
         accepted_o <= 1'b0;
         case (state)
            ST_IDLE: begin
               lreq_o <= 1'b0;
               // Read wins when both are pending
               if (start_rd_i) begin
                  shreg      <= {1'b1, `LREQ_TYPE_RD, addr_i, 1'b0, 8'h00};
                  remain     <= `LREQ_LEN_RD;
                  accepted_o <= 1'b1;
                  state      <= ST_SHIFT;
               end else if (start_wr_i) begin
                  shreg      <= {1'b1, `LREQ_TYPE_WR, addr_i, byte_i, 1'b0};
                  remain     <= `LREQ_LEN_WR;
                  accepted_o <= 1'b1;
                  state      <= ST_SHIFT;
               end
            end
            ST_SHIFT: begin
               lreq_o <= shreg[`LREQ_W-1];
               shreg  <= {shreg[`LREQ_W-2:0], 1'b0};
               remain <= remain - 5'h01;
               if (remain == 5'h01) begin
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end
endmodule

// ==== src/phy_status_rx.v ====
// Purpose: Collects register status returns from the physical layer
// Assumes: Inputs already synchronised; two bits per cycle while status is signalled
// Notes:   A transfer cut short is dropped; 16 bits are status, address, data
`timescale 1ns/1ps
`include "link_diag_defs.vh"
module phy_status_rx (
   input  wire       core_clk_i,
   input  wire       rst_i,
   input  wire [1:0] ctl_i,
   input  wire [1:0] data_i,
   output reg        valid_o,
   output reg  [3:0] addr_o,
   output reg  [7:0] byte_o,
   output wire [1:0] state_o
);
   localparam ST_IDLE = 2'h0;
   localparam ST_RECV = 2'h1;

   reg [1:0]  state;
   reg [15:0] shreg;
   reg [2:0]  pairs;

   assign state_o = state;

   always @(posedge core_clk_i) begin
      if (rst_i) begin
         state   <= ST_IDLE;
         shreg   <= 16'h0000;
         pairs   <= 3'h0;
         valid_o <= 1'b0;
         addr_o  <= 4'h0;
         byte_o  <= 8'h00;
      end else begin
         valid_o <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (ctl_i == `PHY_CTL_STATUS) begin
                  shreg <= {14'h0000, data_i};
                  pairs <= 3'h1;
                  state <= ST_RECV;
               end
            end
            ST_RECV: begin
               if (ctl_i != `PHY_CTL_STATUS) begin
                  state <= ST_IDLE;
               end else begin
                  shreg <= {shreg[13:0], data_i};
                  pairs <= pairs + 3'h1;
                  if (pairs == `STAT_PAIRS) begin
                     addr_o  <= shreg[9:6];
                     byte_o  <= {shreg[5:0], data_i};
                     valid_o <= 1'b1;
                     state   <= ST_IDLE;
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end
endmodule

// ==== bench/link_diag_regs_chk.sv ====
// Purpose: Port-level assertions for the diagnostic and phy access registers
// Assumes: Single core clock, synchronous active-high reset
// Notes:   Mirrors of the diagnostic bits are rebuilt from host writes alone
`timescale 1ns/1ps
module link_diag_regs_chk (
   input wire logic       core_clk_i,
   input wire logic       rst_i,
   input wire logic [7:0] host_addr_i,
   input wire logic [31:0] host_wdata_i,
   input wire logic       host_wr_i,
   input wire logic       host_rd_i,
   input wire logic       host_ack_o,
   input wire logic       phy_lreq_o,
   input wire logic       phy_info_received_irq_o,
   input wire logic       snoop_all_enable_o,
   input wire logic       busy_ack_select_o,
   input wire logic       memory_selftest_mode_o,
   input wire logic [7:0] ram_addr_o,
   input wire logic       ram_tag_o,
   input wire logic       ram_we_o,
   input wire logic       ram_re_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   logic       unl, snp, bsy, tag, tst;
   logic [7:0] exp_a;
   int         low_n;
   wire        dw     = host_wr_i && host_addr_i == 8'h20;
   wire        mode_m = unl && tst;
   always @(posedge core_clk_i) begin
      if (rst_i) begin
         {unl, snp, bsy, tag, tst} <= 5'h00;
         exp_a <= 8'h00;
         low_n <= 0;
      end else begin
         if (dw) begin
            unl <= host_wdata_i[27];
            snp <= host_wdata_i[31];
            // Locked bits use the unlock value held before this write
            if (unl) begin
               bsy <= host_wdata_i[30];
               tag <= host_wdata_i[25];
               tst <= host_wdata_i[23];
            end
         end
         if (dw && unl && host_wdata_i[26]) exp_a <= 8'h00;
         else if (ram_we_o || ram_re_o) exp_a <= exp_a + 8'h01;
         low_n <= phy_lreq_o ? 0 : (low_n < 20 ? low_n + 1 : 20);
      end
   end
   sequence s_test_rd;
      host_rd_i && host_addr_i == 8'h80 && memory_selftest_mode_o;
   endsequence
   sequence s_rd_answer;
      ram_re_o ##2 host_ack_o;
   endsequence
   sequence s_type_tail;
      1'b1 ##1 !phy_lreq_o ##1 phy_lreq_o;
   endsequence
   a_ram_read_lat: assert property (s_test_rd |=> s_rd_answer)
      else $error("test read answer out of step");
   a_ram_write_tag: assert property (
      host_wr_i && host_addr_i == 8'h80 && memory_selftest_mode_o
      |=> ram_we_o && host_ack_o && ram_tag_o == tag)
      else $error("test write pulse or tag wrong");
   a_ram_addr_step: assert property ((ram_we_o || ram_re_o) |-> ram_addr_o == exp_a)
      else $error("test address not stepping");
   a_reg_ack: assert property (
      host_rd_i && (host_addr_i inside {8'h20, 8'h24, 8'h28}) |=> host_ack_o && !ram_re_o)
      else $error("register read not answered");
   a_snoop_follow: assert property (snoop_all_enable_o == $past(snp))
      else $error("snoop enable wrong");
   a_busy_follow: assert property (busy_ack_select_o == $past(bsy))
      else $error("busy select wrong");
   a_mode_gate: assert property (memory_selftest_mode_o == $past(mode_m))
      else $error("test mode gating wrong");
   a_frame_head: assert property (phy_lreq_o && low_n == 20 |=> s_type_tail)
      else $error("request frame head wrong");
   a_irq_pulse: assert property (phy_info_received_irq_o |=> !phy_info_received_irq_o)
      else $error("info interrupt not a pulse");
endmodule

// ==== bench/ram_test_model.sv ====
// Purpose: Internal FIFO RAM seen by the test port, 33-bit words
// Assumes: Read data valid one cycle after the read strobe
// Notes:   Output inverts each cycle when not reading, so data one cycle stale never matches
`timescale 1ns/1ps
module ram_test_model (
   input  wire logic        core_clk_i,
   input  wire logic [7:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        tag_i,
   input  wire logic        we_i,
   input  wire logic        re_i,
   output logic      [31:0] rdata_o,
   output logic             tag_o
);
   logic [32:0] mem [0:255];
   initial {tag_o, rdata_o} = 33'h0;
   always @(posedge core_clk_i) begin
      if (we_i) mem[addr_i] <= {tag_i, wdata_i};
      if (re_i) {tag_o, rdata_o} <= mem[addr_i];
      else {tag_o, rdata_o} <= ~{tag_o, rdata_o};
   end
endmodule

// ==== bench/tb_link_diag_regs.sv ====
// Purpose: Self-checking bench for the diagnostic and phy access registers
// Assumes: Phy pins driven by the bench; RAM from the partner model
// Notes:   Gap flags are expected set after a long idle
`timescale 1ns/1ps
module tb_link_diag_regs;
   logic        core_clk_i = 0;
   logic        rst_i = 1;
   logic [7:0]  host_addr_i = 8'h00;
   logic [31:0] host_wdata_i = 32'h0;
   logic        host_wr_i = 0;
   logic        host_rd_i = 0;
   logic [1:0]  phy_ctl_i = 2'h0;
   logic [1:0]  phy_data_i = 2'h0;
   logic [3:0]  tx_iface_fsm_state_i = 4'h0;
   logic [2:0]  rx_data_iface_fsm_state_i = 3'h0;
   logic [2:0]  rx_ack_fsm_state_i = 3'h0;
   wire  [31:0] host_rdata_o, ram_wdata_o, ram_rdata_i;
   wire  [7:0]  ram_addr_o;
   wire         host_ack_o, phy_lreq_o, phy_info_received_irq_o, snoop_all_enable_o;
   wire         busy_ack_select_o, memory_selftest_mode_o, ram_tag_o, ram_we_o, ram_re_o;
   wire         ram_tag_i;
   integer      seed = 32'hb35c;
   int          error_cnt = 0;
   int          comparisons = 0, i;
   logic [31:0] q, w;
   logic [31:0] d [0:3];
   logic [15:0] v;
   logic [3:0]  a;
   logic [7:0]  b;
   always #10 core_clk_i = ~core_clk_i;
   link_diag_regs u_dut (.core_clk_i, .rst_i, .host_addr_i, .host_wdata_i, .host_wr_i,
      .host_rd_i, .host_rdata_o, .host_ack_o, .phy_ctl_i, .phy_data_i, .phy_lreq_o,
      .phy_info_received_irq_o, .snoop_all_enable_o, .busy_ack_select_o,
      .memory_selftest_mode_o, .ram_addr_o, .ram_wdata_o, .ram_tag_o, .ram_we_o, .ram_re_o,
      .ram_rdata_i, .ram_tag_i, .tx_iface_fsm_state_i, .rx_data_iface_fsm_state_i,
      .rx_ack_fsm_state_i);
   ram_test_model u_ram (.core_clk_i, .addr_i(ram_addr_o), .wdata_i(ram_wdata_o),
      .tag_i(ram_tag_o), .we_i(ram_we_o), .re_i(ram_re_o), .rdata_o(ram_rdata_i),
      .tag_o(ram_tag_i));
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task wrap_up;
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task acc(input logic wr, input logic [7:0] ad, input logic [31:0] dat);
      int n;
      host_addr_i <= ad;
      host_wdata_i <= dat;
      host_wr_i <= wr;
      host_rd_i <= !wr;
      @(posedge core_clk_i);
      host_wr_i <= 0;
      host_rd_i <= 0;
      for (n = 0; n < 8; n++) begin
         #1;
         if (host_ack_o === 1'b1) break;
         @(posedge core_clk_i);
      end
      if (n == 8) begin
         chk("ack", 1, 0);
         wrap_up;
      end
      q = host_rdata_o;
      @(posedge core_clk_i);
   endtask
   task frame(input int nb, input logic [31:0] e);
      int n;
      logic [31:0] f;
      f = 0;
      for (n = 0; n < 40; n++) begin
         #1;
         if (phy_lreq_o === 1'b1) break;
         @(posedge core_clk_i);
      end
      for (n = 0; n < nb; n++) begin
         f = {f[30:0], phy_lreq_o};
         @(posedge core_clk_i);
         #1;
      end
      @(posedge core_clk_i);
      chk("frame", e, f);
   endtask
   initial begin
      repeat (10) @(posedge core_clk_i);
      rst_i <= 0;
      acc(0, 8'h20, 0); chk("diag_rst", 0, q);
      acc(0, 8'h24, 0); chk("access_rst", 0, q);
      acc(0, 8'h28, 0); chk("state_rst", 0, q);
      repeat (110) @(posedge core_clk_i);
      acc(1, 8'h20, 32'hF7FFFFFF);
      acc(0, 8'h20, 0); chk("diag_locked", 32'hB0000000, q);
      acc(1, 8'h20, 32'h08000000);
      for (i = 0; i < 6; i++) begin
         w = ($random(seed) | 32'h08000000) & 32'hFB7FFFFF;
         acc(1, 8'h20, w);
         acc(0, 8'h20, 0); chk("diag_open", w & 32'hFF800000, q);
      end
      acc(1, 8'h20, 32'h0E800000);
      for (i = 0; i < 4; i++) begin
         d[i] = $random(seed);
         acc(1, 8'h80, d[i]);
      end
      acc(1, 8'h20, 32'h0C800000);
      for (i = 0; i < 4; i++) begin
         acc(0, 8'h80, 0); chk("ram_data", d[i], q);
      end
      acc(0, 8'h20, 0); chk("diag_tag_err", 32'h09800000, q);
      acc(1, 8'h20, 32'h0C800000);
      acc(0, 8'h20, 0); chk("diag_err_clr", 32'h08800000, q);
      acc(1, 8'h20, 32'h00800000);
      acc(0, 8'h80, 0); chk("ram_gated", 0, q);
      for (i = 0; i < 2; i++) begin
         a = $random(seed);
         b = $random(seed);
         w = {!i[0], i[0], 2'b00, a, b, 16'h0000};
         acc(1, 8'h24, w);
         if (i) frame(17, {1'b1, 3'h5, a, b, 1'b0});
         else frame(9, {1'b1, 3'h1, a, 1'b0});
         acc(0, 8'h24, 0); chk("access_req", w & 32'h0FFF0000, q & 32'hCFFF0000);
      end
      v = $random(seed);
      for (i = 0; i < 8; i++) begin
         phy_ctl_i <= 2'h1;
         phy_data_i <= v[15 - 2 * i -: 2];
         @(posedge core_clk_i);
      end
      phy_ctl_i <= 2'h0;
      phy_data_i <= ~v[1:0];
      for (i = 0; i < 20; i++) begin
         #1;
         if (phy_info_received_irq_o === 1'b1) break;
         @(posedge core_clk_i);
      end
      @(posedge core_clk_i);
      chk("irq_seen", 1, i < 20);
      acc(0, 8'h24, 0); chk("phy_return", {20'h0, v[11:0]}, q & 32'hC000FFFF);
      tx_iface_fsm_state_i <= $random(seed);
      rx_data_iface_fsm_state_i <= $random(seed);
      rx_ack_fsm_state_i <= $random(seed);
      acc(1, 8'h28, 32'hFFFFFFFF);
      acc(0, 8'h28, 0);
      chk("state", {20'h0, tx_iface_fsm_state_i, rx_data_iface_fsm_state_i, 2'b00,
         rx_ack_fsm_state_i}, q);
      acc(0, 8'h44, 0); chk("unmapped", 0, q);
      wrap_up;
   end
   initial begin
      repeat (100000) @(posedge core_clk_i);
      chk("timeout", 1, 0);
      wrap_up;
   end
endmodule
bind link_diag_regs link_diag_regs_chk u_chk (.core_clk_i, .rst_i, .host_addr_i,
   .host_wdata_i, .host_wr_i, .host_rd_i, .host_ack_o, .phy_lreq_o, .phy_info_received_irq_o,
   .snoop_all_enable_o, .busy_ack_select_o, .memory_selftest_mode_o, .ram_addr_o, .ram_tag_o,
   .ram_we_o, .ram_re_o);
